/* File: src/redundancy_regs.svh */
// Purpose: Constants of the standby redundancy controller
// Assumes: 25 MHz controller clock, load share read as a code
// Notes:   Definitions only
`ifndef REDUNDANCY_REGS_SVH
`define REDUNDANCY_REGS_SVH

// ------------------------------------------------------------
// Command codes and reset values
// ------------------------------------------------------------
`define CMD_ROLE_CONFIG    8'hd0
`define ROLE_RESET         8'h00
`define COMM_RESET         8'h00

// ------------------------------------------------------------
// Role byte encodings
// ------------------------------------------------------------
`define ROLE_STANDARD      8'h00
`define ROLE_ACTIVE        8'h01
`define ROLE_STANDBY1      8'h02
`define ROLE_STANDBY2      8'h03
`define ROLE_STANDBY3      8'h04
`define ROLE_ALWAYS_STBY   8'h05

// ------------------------------------------------------------
// Communication status bit positions
// ------------------------------------------------------------
`define COMM_CMD_BIT       7
`define COMM_DATA_BIT      6
`define COMM_PEC_BIT       5

// ------------------------------------------------------------
// Load share levels in millivolts
// ------------------------------------------------------------
`define LS_FULL_MV         8000
`define EN1_MV             3200
`define DIS1_MV            1440
`define EN2_MV             5000
`define DIS2_MV            3010
`define EN3_MV             6700
`define DIS3_MV            4520

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS      40
`define WAKE_MAX_NS        100000
`define WAKE_RESP_CYC      4

`endif

/* File: src/redundancy_pkg.sv */
// Purpose: Types of the standby redundancy controller
// Assumes: Constants come from the header
// Notes:   Role values match the role byte
`include "redundancy_regs.svh"

package redundancy_pkg;

    // --------------------------------------------------------
    // Roles and load state
    // --------------------------------------------------------
    typedef enum logic [7:0] {
        ROLE_STANDARD    = `ROLE_STANDARD,
        ROLE_ACTIVE      = `ROLE_ACTIVE,
        ROLE_STANDBY1    = `ROLE_STANDBY1,
        ROLE_STANDBY2    = `ROLE_STANDBY2,
        ROLE_STANDBY3    = `ROLE_STANDBY3,
        ROLE_ALWAYS_STBY = `ROLE_ALWAYS_STBY
    } role_t;

    typedef enum logic {
        LOAD_IDLE = 1'b0,
        LOAD_RUN  = 1'b1
    } load_state_t;

    // --------------------------------------------------------
    // Controller state
    // --------------------------------------------------------
    typedef struct packed {
        role_t       role;
        logic [7:0]  comm;
        logic        wake_prev;
        load_state_t load_st;
        logic        conv_on_n;
        logic        wake_out;
        logic        wake_oe;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
    } ctl_state_t;

endpackage

/* File: src/sync_2ff.sv */
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are levels from outside the clock domain
// Notes:   First stage feeds only the second stage
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_2ff needs WIDTH of at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;

endmodule // sync_2ff

/* File: src/standby_redundancy_control.sv */
// Purpose: Decides whether the main converter runs or stands by
// Assumes: Wake bus has a weak pull-down; load share is a code
// Notes:   Management bus framing and PEC done by the bus engine
//
// How it works
// - Pull wake bus low on any fault
// - Standby supply runs within 100 us of wake
// - Undriven wake bus forces every supply on
// - Reset behaves as standard always-on supply
// - Standby positions off only if bus high, load low
// - Standby position selects the load share threshold
// - Position one levels 3.2 V and 1.44 V
// - Position two levels 5.0 V and 3.01 V
// - Position three levels 6.7 V and 4.52 V
// - Load share full scale is 8.0 V
// - Standard and active roles always run converter
// - Wake bus tri-state or high healthy, low faulted
// - Role byte at command D0h, PEC checked
// - Role byte decode 00h to 05h
// - Role 05h stays standby whatever the load
// - Wake bus fall returns standby roles to 00h
// - Standby needs an active supply driving the bus high
// - Load enable compares against host chosen level
// - Unsupported writes rejected, data flag set
`include "redundancy_regs.svh"

module standby_redundancy_control #(
    parameter int LS_BITS    = 10,
    parameter int LS_FULL_MV = `LS_FULL_MV,
    parameter int EN1_MV     = `EN1_MV,
    parameter int DIS1_MV    = `DIS1_MV,
    parameter int EN2_MV     = `EN2_MV,
    parameter int DIS2_MV    = `DIS2_MV,
    parameter int EN3_MV     = `EN3_MV,
    parameter int DIS3_MV    = `DIS3_MV
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               wake_bus_in,
    output logic                    wake_bus_out,
    output logic                    wake_bus_oe,
    input  wire logic               fault_in,
    input  wire logic               vout_low_in,
    input  wire logic [LS_BITS-1:0] ls_level,
    input  wire logic               cmd_valid,
    input  wire logic               cmd_write,
    input  wire logic [7:0]         cmd_code,
    input  wire logic [7:0]         cmd_wdata,
    input  wire logic               cmd_pec_ok,
    input  wire logic               comm_status_clr,
    output logic                    rsp_valid,
    output logic [7:0]              rsp_data,
    output logic [7:0]              comm_status,
    output logic [7:0]              role_config,
    output logic                    converter_on_n
);

    // --------------------------------------------------------
    // Threshold codes
    // --------------------------------------------------------
    localparam int FULL_CODE = (1 << LS_BITS) - 1;

    localparam logic [LS_BITS-1:0] EN1_CODE =
        LS_BITS'(EN1_MV * FULL_CODE / LS_FULL_MV);
    localparam logic [LS_BITS-1:0] DIS1_CODE =
        LS_BITS'(DIS1_MV * FULL_CODE / LS_FULL_MV);
    localparam logic [LS_BITS-1:0] EN2_CODE =
        LS_BITS'(EN2_MV * FULL_CODE / LS_FULL_MV);
    localparam logic [LS_BITS-1:0] DIS2_CODE =
        LS_BITS'(DIS2_MV * FULL_CODE / LS_FULL_MV);
    localparam logic [LS_BITS-1:0] EN3_CODE =
        LS_BITS'(EN3_MV * FULL_CODE / LS_FULL_MV);
    localparam logic [LS_BITS-1:0] DIS3_CODE =
        LS_BITS'(DIS3_MV * FULL_CODE / LS_FULL_MV);

    localparam int WAKE_MAX_CYC = `WAKE_MAX_NS / `CLK_PERIOD_NS;

    // --------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------
    if (LS_BITS < 4 || LS_BITS > 16) begin : g_bad_bits
        $error("LS_BITS must lie between 4 and 16");
    end
    if (DIS1_MV >= EN1_MV || DIS2_MV >= EN2_MV ||
        DIS3_MV >= EN3_MV) begin : g_bad_hyst
        $error("Disable levels must lie below enable levels");
    end
    if (EN3_MV > LS_FULL_MV) begin : g_bad_scale
        $error("Enable levels must not exceed full scale");
    end
    if (WAKE_MAX_CYC < `WAKE_RESP_CYC) begin : g_bad_wake
        $error("Clock too slow for the wake response time");
    end

    // --------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------
    logic [2:0] pins_s;
    logic       wake_s;
    logic       fault_s;
    logic       vlow_s;

    sync_2ff #(
        .WIDTH    (3)
    ) u_pin_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({wake_bus_in, fault_in, vout_low_in}),
        .sync_out (pins_s)
    );

    assign wake_s  = pins_s[2];
    assign fault_s = pins_s[1];
    assign vlow_s  = pins_s[0];

    // --------------------------------------------------------
    // State
    // --------------------------------------------------------
    redundancy_pkg::ctl_state_t ctl_q;
    redundancy_pkg::ctl_state_t ctl_d;

    logic               fault_any;
    logic               wake_fall;
    logic               is_position;
    logic               is_standby;
    logic               always_on;
    logic [LS_BITS-1:0] en_code;
    logic [LS_BITS-1:0] dis_code;
    logic               over_en;
    logic               under_dis;
    logic               run;
    logic               role_wr;
    logic               role_wr_ok;

    // --------------------------------------------------------
    // Decode
    // --------------------------------------------------------
    assign fault_any = fault_s | vlow_s;
    assign wake_fall = ctl_q.wake_prev & ~wake_s;

    assign is_position =
        ctl_q.role == redundancy_pkg::ROLE_STANDBY1 ||
        ctl_q.role == redundancy_pkg::ROLE_STANDBY2 ||
        ctl_q.role == redundancy_pkg::ROLE_STANDBY3;
    assign is_standby = is_position ||
        ctl_q.role == redundancy_pkg::ROLE_ALWAYS_STBY;
    assign always_on = ~is_standby;

    // Threshold chosen by the host programmed position
    assign en_code =
        ctl_q.role == redundancy_pkg::ROLE_STANDBY1 ? EN1_CODE :
        ctl_q.role == redundancy_pkg::ROLE_STANDBY2 ? EN2_CODE :
        EN3_CODE;
    assign dis_code =
        ctl_q.role == redundancy_pkg::ROLE_STANDBY1 ? DIS1_CODE :
        ctl_q.role == redundancy_pkg::ROLE_STANDBY2 ? DIS2_CODE :
        DIS3_CODE;

    assign over_en   = is_position && ls_level > en_code;
    assign under_dis = ls_level < dis_code;

    // Low bus covers both a fault and nobody driving high
    assign run = always_on || ~wake_s || over_en ||
        (is_position &&
         ctl_q.load_st == redundancy_pkg::LOAD_RUN);

    assign role_wr = cmd_valid && cmd_write &&
        cmd_code == `CMD_ROLE_CONFIG;
    assign role_wr_ok = role_wr && cmd_pec_ok &&
        cmd_wdata <= `ROLE_ALWAYS_STBY;

    // --------------------------------------------------------
    // Next state
    // --------------------------------------------------------
    always_comb begin
        ctl_d = ctl_q;
        ctl_d.wake_prev = wake_s;
        ctl_d.rsp_valid = 1'b0;

        // Load hysteresis
        case (ctl_q.load_st)
            redundancy_pkg::LOAD_IDLE: begin
                if (over_en) begin
                    ctl_d.load_st = redundancy_pkg::LOAD_RUN;
                end
            end
            redundancy_pkg::LOAD_RUN: begin
                if (!is_position || under_dis) begin
                    ctl_d.load_st = redundancy_pkg::LOAD_IDLE;
                end
            end
            default: begin
                ctl_d.load_st = redundancy_pkg::LOAD_IDLE;
            end
        endcase

        ctl_d.conv_on_n = ~run;

        // Wake bus drive
        if (fault_any) begin
            ctl_d.wake_oe  = 1'b1;
            ctl_d.wake_out = 1'b0;
        end else if (ctl_q.role == redundancy_pkg::ROLE_ACTIVE) begin
            ctl_d.wake_oe  = 1'b1;
            ctl_d.wake_out = 1'b1;
        end else begin
            ctl_d.wake_oe  = 1'b0;
            ctl_d.wake_out = 1'b0;
        end

        // Status clear, then new events so that a set wins
        if (comm_status_clr) begin
            ctl_d.comm = `COMM_RESET;
        end

        // Management bus commands
        if (cmd_valid) begin
            if (cmd_code == `CMD_ROLE_CONFIG) begin
                if (!cmd_write) begin
                    ctl_d.rsp_valid = 1'b1;
                    ctl_d.rsp_data  = ctl_q.role;
                end else if (!cmd_pec_ok) begin
                    ctl_d.comm[`COMM_PEC_BIT] = 1'b1;
                end else if (role_wr_ok) begin
                    ctl_d.role =
                        redundancy_pkg::role_t'(cmd_wdata);
                end else begin
                    ctl_d.comm[`COMM_DATA_BIT] = 1'b1;
                end
            end else if (cmd_write) begin
                ctl_d.comm[`COMM_DATA_BIT] = 1'b1;
            end else begin
                ctl_d.comm[`COMM_CMD_BIT] = 1'b1;
                ctl_d.rsp_valid = 1'b1;
                ctl_d.rsp_data  = 8'h00;
            end
        end

        // Wake event overrides a same cycle host write
        if (wake_fall && is_standby) begin
            ctl_d.role = redundancy_pkg::ROLE_STANDARD;
            ctl_d.load_st = redundancy_pkg::LOAD_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= '{
                role:      redundancy_pkg::role_t'(`ROLE_RESET),
                comm:      `COMM_RESET,
                load_st:   redundancy_pkg::LOAD_IDLE,
                default:   '0
            };
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // --------------------------------------------------------
    // Outputs
    // --------------------------------------------------------
    assign wake_bus_out   = ctl_q.wake_out;
    assign wake_bus_oe    = ctl_q.wake_oe;
    assign converter_on_n = ctl_q.conv_on_n;
    assign rsp_valid      = ctl_q.rsp_valid;
    assign rsp_data       = ctl_q.rsp_data;
    assign comm_status    = ctl_q.comm;
    assign role_config    = ctl_q.role;

    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    a_fault_pulls_low: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(fault_in) ##2 fault_in |=> (wake_bus_oe && !wake_bus_out)
    ) else $error("Fault did not pull the wake bus low");

    a_wake_response: assert property (
        @(posedge mclk) disable iff (rst)
        ($fell(wake_bus_in) && is_standby)
            ##1 !wake_bus_in[*2]
        |-> ##[0:2] !converter_on_n
    ) else $error("Standby supply slow to start after wake");

    a_undriven_runs: assert property (
        @(posedge mclk) disable iff (rst)
        !wake_s |=> !converter_on_n
    ) else $error("Converter off while wake bus low");

    a_reset_default: assert property (
        @(posedge mclk)
        $past(rst) && !rst |->
            (role_config == `ROLE_RESET && !converter_on_n
             && !wake_bus_oe)
    ) else $error("Reset did not give standard running state");

    a_standby_off: assert property (
        @(posedge mclk) disable iff (rst)
        (is_standby && wake_s && !over_en && !wake_fall &&
         ctl_q.load_st == redundancy_pkg::LOAD_IDLE)
        |=> converter_on_n
    ) else $error("Standby supply running without cause");

    a_enable_level: assert property (
        @(posedge mclk) disable iff (rst)
        (is_position && ls_level > en_code) |=> !converter_on_n
    ) else $error("Load above enable level left converter off");

    a_always_on: assert property (
        @(posedge mclk) disable iff (rst)
        always_on |=> !converter_on_n
    ) else $error("Always-on role stopped its converter");

    a_active_drive: assert property (
        @(posedge mclk) disable iff (rst)
        (ctl_q.role == redundancy_pkg::ROLE_ACTIVE && !fault_any)
        |=> (wake_bus_oe && wake_bus_out)
    ) else $error("Healthy active supply not driving high");

    a_healthy_float: assert property (
        @(posedge mclk) disable iff (rst)
        (ctl_q.role != redundancy_pkg::ROLE_ACTIVE && !fault_any)
        |=> !wake_bus_oe
    ) else $error("Healthy passive supply drove the wake bus");

    a_role_write: assert property (
        @(posedge mclk) disable iff (rst)
        (role_wr_ok && !(wake_fall && is_standby))
        |=> role_config == $past(cmd_wdata)
    ) else $error("Valid role write not stored");

    a_always_stby: assert property (
        @(posedge mclk) disable iff (rst)
        (ctl_q.role == redundancy_pkg::ROLE_ALWAYS_STBY && wake_s
         && !wake_fall) |=> converter_on_n
    ) else $error("Always-standby supply ran on a high bus");

    a_wake_rewrite: assert property (
        @(posedge mclk) disable iff (rst)
        (wake_fall && is_standby)
        |=> role_config == `ROLE_STANDARD
    ) else $error("Wake event did not restore standard role");

    a_hyst_hold: assert property (
        @(posedge mclk) disable iff (rst)
        (ctl_q.load_st == redundancy_pkg::LOAD_RUN && is_position
         && !under_dis && !wake_fall && !role_wr)
        |=> ctl_q.load_st == redundancy_pkg::LOAD_RUN
    ) else $error("Standby supply left run above disable level");

    a_bad_write_flag: assert property (
        @(posedge mclk) disable iff (rst)
        (cmd_valid && cmd_write && cmd_code != `CMD_ROLE_CONFIG)
        |=> comm_status[`COMM_DATA_BIT]
    ) else $error("Unsupported write not flagged");

endmodule // standby_redundancy_control

/* File: testbench/peer_supplies.sv */
// Purpose: Other supplies sharing the wake bus
// Assumes: Weak pull-down on the bus
// Notes:   Low from anyone wins over high
module peer_supplies (
    input  wire logic peer_hi,
    input  wire logic peer_lo,
    input  wire logic dut_out,
    input  wire logic dut_oe,
    output logic      wake_wire
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------
    // Wired bus level
    // ----------------------------------------------------
    always_comb begin
        if (peer_lo || (dut_oe && !dut_out)) begin
            wake_wire = 1'b0;
        end else if (peer_hi || (dut_oe && dut_out)) begin
            wake_wire = 1'b1;
        end else begin
            wake_wire = 1'b0;
        end
    end
endmodule // peer_supplies

/* File: testbench/standby_redundancy_control_tb_top.sv */
// Purpose: Self-checking bench of the standby controller
// Assumes: One peer on the wake bus, seed 99
// Notes:   Waits follow the hand-over latencies
`include "redundancy_regs.svh"

module standby_redundancy_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk = 1'b0;
    logic       rst, fault_in, vout_low_in, cmd_valid, cmd_write;
    logic       cmd_pec_ok, comm_status_clr, peer_hi, peer_lo;
    logic       wake_wire, wake_bus_out, wake_bus_oe;
    logic       rsp_valid, converter_on_n;
    logic [9:0] ls_level;
    logic [7:0] cmd_code, cmd_wdata, rsp_data, comm_status, role_config;
    int         fail_count, compares, cyc, en, dis;
    int         en_mv[3]  = '{`EN1_MV, `EN2_MV, `EN3_MV};
    int         dis_mv[3] = '{`DIS1_MV, `DIS2_MV, `DIS3_MV};

    standby_redundancy_control i_dut (
        .mclk(mclk), .rst(rst), .wake_bus_in(wake_wire),
        .wake_bus_out(wake_bus_out), .wake_bus_oe(wake_bus_oe),
        .fault_in(fault_in), .vout_low_in(vout_low_in),
        .ls_level(ls_level), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_pec_ok(cmd_pec_ok),
        .comm_status_clr(comm_status_clr), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .comm_status(comm_status),
        .role_config(role_config), .converter_on_n(converter_on_n)
    );

    peer_supplies i_peer (
        .peer_hi(peer_hi), .peer_lo(peer_lo), .dut_out(wake_bus_out),
        .dut_oe(wake_bus_oe), .wake_wire(wake_wire)
    );

    always #20 mclk = ~mclk;

    // ----------------------------------------------------
    // Helpers
    // ----------------------------------------------------
    function automatic int code(input int mv);
        return mv * 1023 / `LS_FULL_MV;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] c, d, input logic pec);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b1;
        cmd_code <= c;
        cmd_wdata <= d;
        cmd_pec_ok <= pec;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] c, exp);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b0;
        cmd_code <= c;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
        chk(rsp_valid, 1'b1);
        chk(rsp_data, exp);
        tick(1);
        chk(rsp_valid, 1'b0);
    endtask

    task automatic set_ls(input int v);
        @(posedge mclk);
        ls_level <= 10'(v);
    endtask

    task automatic set_peer(input logic hi, lo);
        @(posedge mclk);
        peer_hi <= hi;
        peer_lo <= lo;
    endtask

    task automatic complete_run();
        $display("counts compares %0d bad %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    // ----------------------------------------------------
    // Tests
    // ----------------------------------------------------
    initial begin
        {fault_in, vout_low_in, cmd_valid, cmd_write} = '0;
        {cmd_pec_ok, comm_status_clr, peer_hi, peer_lo} = '0;
        {ls_level, cmd_code, cmd_wdata} = '0;
        {fail_count, compares, cyc} = '0;
        rst = 1'b1;
        void'($urandom(99));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        chk(converter_on_n, 1'b0);
        chk(role_config, `ROLE_RESET);
        chk(wake_bus_oe, 1'b0);
        $display("test reset done");
        for (int r = 5; r >= 0; r--) begin
            wr(`CMD_ROLE_CONFIG, 8'(r), 1'b1);
            chk(role_config, 8'(r));
            rd(`CMD_ROLE_CONFIG, 8'(r));
            tick(4);
            chk(converter_on_n, 1'b0);
        end
        wr(`CMD_ROLE_CONFIG, 8'h06, 1'b1);
        chk(comm_status[6], 1'b1);
        wr(`CMD_ROLE_CONFIG, 8'h02, 1'b0);
        chk(comm_status[5], 1'b1);
        chk(role_config, `ROLE_STANDARD);
        wr(8'($urandom) | 8'h01, 8'h01, 1'b1);
        rd(8'h21, 8'h00);
        chk(comm_status, 8'he0);
        @(posedge mclk);
        comm_status_clr <= 1'b1;
        @(posedge mclk);
        comm_status_clr <= 1'b0;
        #1;
        chk(comm_status, 8'h00);
        @(posedge mclk);
        comm_status_clr <= 1'b1;
        cmd_valid <= 1'b1;
        cmd_write <= 1'b1;
        cmd_code <= 8'h21;
        cmd_pec_ok <= 1'b1;
        @(posedge mclk);
        comm_status_clr <= 1'b0;
        cmd_valid <= 1'b0;
        #1;
        chk(comm_status, 8'h40);
        $display("test commands done");
        set_peer(1'b1, 1'b0);
        for (int p = 0; p < 3; p++) begin
            en = code(en_mv[p]);
            dis = code(dis_mv[p]);
            wr(`CMD_ROLE_CONFIG, 8'(`ROLE_STANDBY1 + p), 1'b1);
            set_ls(en);
            tick(4);
            chk(converter_on_n, 1'b1);
            set_ls(en + 1 + $urandom % (1023 - en));
            tick(4);
            chk(converter_on_n, 1'b0);
            set_ls(dis + $urandom % (en - dis));
            tick(4);
            chk(converter_on_n, 1'b0);
            set_ls($urandom % dis);
            tick(4);
            chk(converter_on_n, 1'b1);
        end
        wr(`CMD_ROLE_CONFIG, `ROLE_ALWAYS_STBY, 1'b1);
        set_ls(1023);
        tick(4);
        chk(converter_on_n, 1'b1);
        wr(`CMD_ROLE_CONFIG, `ROLE_ACTIVE, 1'b1);
        set_ls(0);
        tick(4);
        chk(converter_on_n, 1'b0);
        chk({wake_bus_oe, wake_bus_out}, 2'b11);
        wr(`CMD_ROLE_CONFIG, `ROLE_STANDARD, 1'b1);
        tick(4);
        chk({wake_bus_oe, converter_on_n}, 2'b00);
        $display("test load done");
        wr(`CMD_ROLE_CONFIG, `ROLE_STANDBY2, 1'b1);
        tick(4);
        chk(converter_on_n, 1'b1);
        set_peer(1'b0, 1'b1);
        tick(4);
        chk(converter_on_n, 1'b0);
        chk(role_config, `ROLE_STANDARD);
        set_peer(1'b1, 1'b0);
        tick(4);
        chk(converter_on_n, 1'b0);
        wr(`CMD_ROLE_CONFIG, `ROLE_STANDBY2, 1'b1);
        tick(4);
        chk(converter_on_n, 1'b1);
        $display("test wake done");
        @(posedge mclk);
        fault_in <= 1'b1;
        tick(4);
        chk({wake_bus_oe, wake_bus_out}, 2'b10);
        tick(3);
        chk(converter_on_n, 1'b0);
        chk(role_config, `ROLE_STANDARD);
        @(posedge mclk);
        fault_in <= 1'b0;
        vout_low_in <= 1'b1;
        tick(4);
        chk({wake_bus_oe, wake_bus_out}, 2'b10);
        @(posedge mclk);
        vout_low_in <= 1'b0;
        tick(4);
        chk(wake_bus_oe, 1'b0);
        $display("test fault done");
        wr(`CMD_ROLE_CONFIG, `ROLE_ACTIVE, 1'b1);
        @(posedge mclk);
        rst <= 1'b1;
        tick(3);
        @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        chk(role_config, `ROLE_RESET);
        chk({wake_bus_oe, converter_on_n}, 2'b00);
        chk(comm_status, 8'h00);
        $display("test reset again done");
        complete_run();
    end
endmodule // standby_redundancy_control_tb_top
